/* shared/rcc_pkg.sv */
// constants shared by the reset, strap and clock control ends
// How it works
// - base strap picks 164Eh or 2Eh pair
// - float strap low floats all pins
// - test strap low with float strap high selects xor chain
// - xor chain result drives dedicated output
// - power-up reset releases straps, enables pull-ups
// - power-up latches straps then does hardware reset
// - no answer to cycles during power-up reset
// - host reset low restores config defaults, locks
// - bus clock domain versus separate 48 MHz domain
// - host keeps bus clock valid through reset
// - bus clock may stop; both tolerate it
// - 48 MHz from pin or from generator
// - 48 MHz clock disabled after any reset
// - generator starts on enable bit rising
// - output held until generator is stable
// - generator waits for a toggling reference
// - ready bit 0 frozen, 1 toggling
// - software polls ready before enabling ports
// - disabled generator fully gated
// - software sets source, enables, polls ready
// - generator stable within 33 ms
// - test mode decoded from both latched straps
package rcc_pkg;

  // ************************************************
  // configuration port addresses and indices
  // ************************************************
  localparam logic [15:0] BASE_HIGH     = 16'h164E;
  localparam logic [15:0] BASE_LOW      = 16'h002E;
  localparam logic [7:0]  IDX_LDN       = 8'h07;
  localparam logic [7:0]  IDX_CLKGEN    = 8'h29;
  localparam logic [7:0]  IDX_DMA0      = 8'h74;
  localparam logic [7:0]  IDX_DMA1      = 8'h75;
  localparam logic [7:0]  DMA_NONE      = 8'h04;
  localparam logic [7:0]  INDEX_RESET   = 8'h00;
  localparam logic [7:0]  LDN_RESET     = 8'h00;

  // ************************************************
  // clock_generator_control fields
  // ************************************************
  localparam int CG_ENABLE = 7;
  localparam int CG_SOURCE = 5;  // 1: 14.31818 MHz via generator
  localparam int CG_READY  = 4;
  localparam int CG_LOCK   = 0;

  // ************************************************
  // strap vector positions and reset value
  // ************************************************
  localparam int          STRAP_BASE  = 0;
  localparam int          STRAP_FLOAT = 1;
  localparam int          STRAP_XOR   = 2;
  localparam logic [2:0]  STRAP_RESET = 3'h7;

  // ************************************************
  // timing
  // ************************************************
  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned WAKE_MS        = 33;
  localparam int unsigned WAKE_CYC       = WAKE_MS * CLK_KHZ;
  localparam int unsigned SYNC_TIMEOUT   = 64;

  // ************************************************
  // host register map (axi4-lite byte offsets)
  // ************************************************
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_CMD       = 4'h4;
  localparam logic [3:0]  REG_STATUS    = 4'h8;
  localparam logic [3:0]  REG_STRAP     = 4'hC;
  localparam int          CTRL_RELEASE  = 0;
  localparam int          CTRL_STOPOK   = 1;
  localparam int          CMD_WRITE     = 24;
  localparam int          ST_BUSY       = 0;
  localparam int          ST_DONE       = 1;
  localparam int          ST_NOSYNC     = 2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

/* shared/rcc_link_if.sv */
// link between the host controller end and the device end
`timescale 1ns/10ps
interface rcc_link_if;
  logic        lreset_n;      // host reset, low active
  logic        bus_run;       // bus clock running
  logic        clk_keep;      // device asks clock to keep running
  logic        io_valid;
  logic        io_write;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic        io_sync;
  logic [7:0]  io_rdata;
  logic [2:0]  strap_level;   // board strap levels
  logic        strap_pu_en;   // device pull-ups on strap pins
  logic        strap_drive_oe;

  modport dev (input lreset_n, bus_run, io_valid, io_write, io_addr, io_wdata, strap_level,
               output clk_keep, io_sync, io_rdata, strap_pu_en, strap_drive_oe);
  modport host (output lreset_n, bus_run, io_valid, io_write, io_addr, io_wdata, strap_level,
                input clk_keep, io_sync, io_rdata, strap_pu_en, strap_drive_oe);
endinterface

/* src/rcc_device.sv */
// device end: power-up and host reset, straps, pin test modes, 48 MHz clock control
`timescale 1ns/10ps
module rcc_device
  import rcc_pkg::*;
#(
  parameter int unsigned PINS        = 8,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  // clock, reset, enable
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            ce,
  // link to the host controller
  rcc_link_if.dev              link,
  // reference clock pin (14.31818 MHz or 48 MHz)
  input  wire logic            reference_clock_input,
  // functional logic side of the pins
  input  wire logic [PINS-1:0] func_out,
  input  wire logic [PINS-1:0] func_oe,
  output logic      [PINS-1:0] func_in,
  // pads
  input  wire logic [PINS-1:0] pad_in,
  output logic      [PINS-1:0] pad_out,
  output logic      [PINS-1:0] pad_oe,
  output logic                 xor_out,
  // 48 MHz domain control
  output logic                 clk48_enable,
  output logic                 gen_powered,
  output logic                 gen_ready,
  output logic                 reserved_mode
);

  initial begin
    if (PINS < 3) $error("rcc_device: PINS must cover the three strap pins");
    if (WAKE_CYCLES < 1) $error("rcc_device: WAKE_CYCLES must be at least 1");
  end

  localparam int CW = $clog2(WAKE_CYCLES + 1);

  typedef enum logic [1:0] {RCC_GEN_OFF, RCC_GEN_WAIT_REF, RCC_GEN_SETTLE, RCC_GEN_RUN}
    rcc_gen_t;

  // ************************************************
  // power-up reset phase and straps
  // ************************************************
  logic       por;
  logic [2:0] strap_q;
  logic       host_rst;
  assign host_rst = !link.lreset_n;

  // power-up phase lasts until the host reset goes high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por     <= 1'b1;
      strap_q <= STRAP_RESET;
    end else if (ce) begin
      if (por) begin
        strap_q <= link.strap_level;
      end
      if (por && link.lreset_n) begin
        por <= 1'b0;
      end
    end
  end

  // pins released with pull-ups during power-up only
  assign link.strap_pu_en    = por;
  assign link.strap_drive_oe = !por;

  // test mode from both latched straps; both low floats as the safe choice
  logic mode_float;
  logic mode_xor;
  assign mode_float    = !strap_q[STRAP_FLOAT] && strap_q[STRAP_XOR];
  assign mode_xor      = strap_q[STRAP_FLOAT] && !strap_q[STRAP_XOR];
  assign reserved_mode = !strap_q[STRAP_FLOAT] && !strap_q[STRAP_XOR];

  // ************************************************
  // pads: input synchroniser, float and xor chain
  // ************************************************
  logic [PINS-1:0] pad_s1;
  logic [PINS-1:0] pad_s2;
  logic            xor_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_s1 <= '0;
      pad_s2 <= '0;
      xor_q  <= 1'b0;
    end else if (ce) begin
      pad_s1 <= pad_in;
      pad_s2 <= pad_s1;
      xor_q  <= mode_xor && !por && (^pad_s2);
    end
  end

  logic [PINS-1:0] strap_mask;
  logic            pins_off;
  assign strap_mask = {{(PINS-3){1'b0}}, 3'h7};
  // any test mode makes every pin an input; xor mode needs all pins listening
  assign pins_off = !por && (mode_float || mode_xor || reserved_mode);
  assign pad_oe   = pins_off ? '0 : (por ? (func_oe & ~strap_mask) : func_oe);
  assign pad_out  = func_out;
  assign func_in  = pad_s2;
  assign xor_out  = xor_q;

  // ************************************************
  // configuration registers
  // ************************************************
  logic [7:0] index_q;
  logic [7:0] ldn_q;
  logic       cg_en;
  logic       cg_src;
  logic       cg_lock;
  logic       sync_q;
  logic [7:0] rdata_q;
  rcc_gen_t   gen_state;

  logic [15:0] base;
  logic        hit_index;
  logic        hit_data;
  logic        take;
  logic [7:0]  cg_value;
  logic [7:0]  rd_value;
  assign base      = strap_q[STRAP_BASE] ? BASE_HIGH : BASE_LOW;
  assign hit_index = link.io_addr == base;
  assign hit_data  = link.io_addr == (base + 16'h0001);
  // bus side frozen while the bus clock is stopped, silent during power-up
  assign take      = link.io_valid && !sync_q && (hit_index || hit_data)
                     && !por && link.lreset_n && link.bus_run;
  assign cg_value  = {cg_en, 1'b0, cg_src, gen_ready, 3'h0, cg_lock};

  // indexed read; unknown indices read zero
  function automatic logic [7:0] cfg_read(input logic [7:0] idx, input logic [7:0] ldn,
                                          input logic [7:0] cg);
    if (idx == IDX_LDN) begin
      cfg_read = ldn;
    end else if (idx == IDX_CLKGEN) begin
      cfg_read = cg;
    end else if (idx == IDX_DMA0 || idx == IDX_DMA1) begin
      cfg_read = DMA_NONE;
    end else begin
      cfg_read = 8'h00;
    end
  endfunction

  assign rd_value = hit_index ? index_q : cfg_read(index_q, ldn_q, cg_value);

  // register writes; host reset restores defaults and clears the lock
  always_ff @(posedge aclk) begin
    if (!aresetn || host_rst) begin
      index_q <= INDEX_RESET;
      ldn_q   <= LDN_RESET;
      cg_en   <= 1'b0;
      cg_src  <= 1'b0;
      cg_lock <= 1'b0;
    end else if (ce && take && link.io_write) begin
      if (hit_index) begin
        index_q <= link.io_wdata;
      end else if (index_q == IDX_LDN) begin
        ldn_q <= link.io_wdata;
      end else if (index_q == IDX_CLKGEN && !cg_lock) begin
        cg_en   <= link.io_wdata[CG_ENABLE];
        cg_src  <= link.io_wdata[CG_SOURCE];
        cg_lock <= link.io_wdata[CG_LOCK];
      end
    end
  end

  // one-cycle sync answer with read data
  always_ff @(posedge aclk) begin
    if (!aresetn || host_rst) begin
      sync_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else if (ce) begin
      sync_q <= take;
      if (take) begin
        rdata_q <= link.io_write ? 8'h00 : rd_value;
      end
    end
  end
  assign link.io_sync  = sync_q;
  assign link.io_rdata = rdata_q;

  // ************************************************
  // clock generator sequencer (48 MHz domain control)
  // ************************************************
  logic          ref_s1;
  logic          ref_s2;
  logic          ref_s3;
  logic          en_prev;
  logic [CW-1:0] wake_cnt;
  logic          ref_edge;
  assign ref_edge = ref_s2 != ref_s3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
    end else if (ce) begin
      ref_s1 <= reference_clock_input;                 // runs regardless of host reset
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || host_rst) begin
      gen_state <= RCC_GEN_OFF;
      en_prev   <= 1'b0;
      wake_cnt  <= '0;
    end else if (ce) begin
      en_prev <= cg_en;
      case (gen_state)
        RCC_GEN_OFF: begin
          if (cg_en && !en_prev && cg_src) begin
            gen_state <= RCC_GEN_WAIT_REF;
          end
        end
        RCC_GEN_WAIT_REF: begin
          wake_cnt <= CW'(WAKE_CYCLES - 1);
          if (ref_edge) begin
            gen_state <= RCC_GEN_SETTLE;
          end
        end
        RCC_GEN_SETTLE: begin
          if (wake_cnt == '0) begin
            gen_state <= RCC_GEN_RUN;
          end else begin
            wake_cnt <= wake_cnt - CW'(1);
          end
        end
        RCC_GEN_RUN: begin
          gen_state <= RCC_GEN_RUN;
        end
        default: begin
          gen_state <= RCC_GEN_OFF;
        end
      endcase
      if (!cg_en || !cg_src) begin
        gen_state <= RCC_GEN_OFF;
      end
    end
  end

  // output held frozen until run; direct pin source follows the enable
  assign gen_ready    = cg_en && (cg_src ? (gen_state == RCC_GEN_RUN) : 1'b1);
  assign clk48_enable = cg_en && (cg_src ? (gen_state == RCC_GEN_RUN) : 1'b1);
  assign gen_powered  = gen_state != RCC_GEN_OFF;

  // keep the bus clock while a cycle is pending or unanswered
  assign link.clk_keep = link.io_valid || sync_q;

endmodule

/* src/rcc_host.sv */
// host end: axi4-lite command registers driving reset, straps and i/o cycles
`timescale 1ns/10ps
module rcc_host
  import rcc_pkg::*;
#(
  parameter int unsigned TIMEOUT = SYNC_TIMEOUT
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // link to the device
  rcc_link_if.host         link,
  // axi4-lite slave
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  initial begin
    if (TIMEOUT < 2 || TIMEOUT > 255) $error("rcc_host: TIMEOUT must be 2..255");
  end

  typedef enum logic {RCC_IO_IDLE, RCC_IO_WAIT} rcc_io_t;

  // ************************************************
  // registers
  // ************************************************
  logic [1:0]  ctrl_q;
  logic [2:0]  strap_q;
  logic        done_q;
  logic        nosync_q;
  logic [7:0]  rd_q;
  logic [7:0]  tmo_q;
  rcc_io_t     io_state;
  logic        io_valid_q;
  logic        io_write_q;
  logic [15:0] io_addr_q;
  logic [7:0]  io_wdata_q;

  // write accepted with address and data together
  logic wr_go;
  logic wr_cmd;
  logic wr_hit;
  assign wr_go   = awvalid && wvalid && !bvalid && ce;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign wr_hit  = awaddr == REG_CTRL || awaddr == REG_CMD || awaddr == REG_STRAP;
  // a command while one is running is dropped; software checks busy first
  assign wr_cmd  = wr_go && awaddr == REG_CMD && io_state == RCC_IO_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= 2'h0;
      strap_q <= STRAP_RESET;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        if (awaddr == REG_CTRL && wstrb[0]) begin
          ctrl_q <= wdata[1:0];
        end
        if (awaddr == REG_STRAP && wstrb[0]) begin
          strap_q <= wdata[2:0];
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel, one outstanding
  logic [31:0] rd_mux;
  logic        rd_hit;
  assign arready = !rvalid && ce;
  assign rd_hit  = araddr == REG_CTRL || araddr == REG_STATUS || araddr == REG_STRAP
                   || araddr == REG_CMD;
  assign rd_mux  = (araddr == REG_CTRL)   ? {30'h0, ctrl_q} :
                   (araddr == REG_STRAP)  ? {29'h0, strap_q} :
                   (araddr == REG_CMD)    ? {7'h0, io_write_q, io_wdata_q, io_addr_q} :
                   (araddr == REG_STATUS) ? {16'h0, rd_q, 5'h0, nosync_q, done_q,
                                             io_state == RCC_IO_WAIT} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && !rvalid) begin
        rvalid <= 1'b1;
        rdata  <= rd_mux;
        rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ************************************************
  // i/o cycle engine: wait for sync or give up
  // ************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_state   <= RCC_IO_IDLE;
      io_valid_q <= 1'b0;
      io_write_q <= 1'b0;
      io_addr_q  <= 16'h0000;
      io_wdata_q <= 8'h00;
      done_q     <= 1'b0;
      nosync_q   <= 1'b0;
      rd_q       <= 8'h00;
      tmo_q      <= 8'h00;
    end else if (ce) begin
      case (io_state)
        RCC_IO_IDLE: begin
          if (wr_cmd) begin
            io_state   <= RCC_IO_WAIT;
            io_valid_q <= 1'b1;
            io_addr_q  <= wdata[15:0];
            io_wdata_q <= wdata[23:16];
            io_write_q <= wdata[CMD_WRITE];
            done_q     <= 1'b0;
            nosync_q   <= 1'b0;
            tmo_q      <= 8'(TIMEOUT);
          end
        end
        RCC_IO_WAIT: begin
          if (link.io_sync) begin
            io_state   <= RCC_IO_IDLE;
            io_valid_q <= 1'b0;
            done_q     <= 1'b1;
            rd_q       <= link.io_rdata;
          end else if (tmo_q == 8'h00) begin
            io_state   <= RCC_IO_IDLE;
            io_valid_q <= 1'b0;
            done_q     <= 1'b1;
            nosync_q   <= 1'b1;
          end else begin
            tmo_q <= tmo_q - 8'h01;
          end
        end
        default: begin
          io_state <= RCC_IO_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // link drive
  // ************************************************
  assign link.lreset_n     = ctrl_q[CTRL_RELEASE];
  assign link.strap_level  = strap_q;
  assign link.io_valid     = io_valid_q;
  assign link.io_write     = io_write_q;
  assign link.io_addr      = io_addr_q;
  assign link.io_wdata     = io_wdata_q;
  // clock stops only out of reset, idle, and with no device request
  assign link.bus_run = !ctrl_q[CTRL_RELEASE] || !ctrl_q[CTRL_STOPOK]
                        || link.clk_keep || io_state != RCC_IO_IDLE;

endmodule

/* tb/rcc_sva.sv */
// concurrent checks on the link between the host end and the device end
`timescale 1ns/10ps
module rcc_sva
  import rcc_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // link signals
  input wire logic        lreset_n,
  input wire logic        bus_run,
  input wire logic        io_valid,
  input wire logic [15:0] io_addr,
  input wire logic        io_sync,
  input wire logic [2:0]  strap_level,
  input wire logic        strap_pu_en,
  input wire logic        strap_drive_oe
);
  // base strap as latched; last sample of the power-up phase is kept
  logic        base_q;
  wire  [15:0] base_a = base_q ? BASE_HIGH : BASE_LOW;
  always_ff @(posedge aclk) begin
    if (strap_pu_en) base_q <= strap_level[STRAP_BASE];
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sync_one_cycle: assert property (io_sync |=> !io_sync)
    else $error("sync longer than one cycle");
  a_sync_needs_req: assert property (io_sync |-> $past(io_valid && lreset_n && bus_run))
    else $error("sync without a live request");
  a_sync_base_addr: assert property (io_sync |->
    ($past(io_addr) == base_a || $past(io_addr) == base_a + 16'h1))
    else $error("sync for an address off the strapped pair");
  a_take_answered: assert property ($rose(io_valid) && lreset_n && bus_run && !strap_pu_en
    && (io_addr == base_a || io_addr == base_a + 16'h1) |=> io_sync)
    else $error("valid cycle left unanswered");
  a_host_reset_quiet: assert property (!lreset_n |=> !io_sync)
    else $error("sync while host reset low");
  a_pullup_vs_drive: assert property (strap_pu_en != strap_drive_oe)
    else $error("strap pull-up and drive overlap");
  a_phase_end_release: assert property ($fell(strap_pu_en) |-> $past(lreset_n))
    else $error("power-up phase ended with host reset low");
  a_phase_at_reset: assert property ($rose(aresetn) |-> strap_pu_en && !io_sync)
    else $error("power-up phase not active after reset");

  c_sync: cover property (io_sync);
  c_phase_end: cover property ($fell(strap_pu_en));
  c_refused: cover property (io_valid && !lreset_n);
endmodule

/* tb/tb_top.sv */
// bench: both ends joined, axi stimulus, register model and verdict
`timescale 1ns/10ps
module tb_top
  import rcc_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0, refclk = 1'h0, ce = 1'h1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rd_data, st;
  logic [7:0]  func_out = 8'h0, func_oe = 8'h0, pad_in = 8'h0, func_in, pad_out, pad_oe;
  logic        awready, wready, bvalid, arready, rvalid, xor_out;
  logic        clk48_enable, gen_powered, gen_ready, reserved_mode;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  strap;
  logic [15:0] base_a;
  int          num_errors = 0, comparisons = 0, n;
  int          cfg[int];

  always #2.5 aclk = ~aclk;
  // reference runs free and unrelated in phase to aclk
  always #34.92 refclk = ~refclk;

  rcc_link_if link ();
  rcc_host #(.TIMEOUT(8)) i_rcc_host (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .link(link), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  rcc_device #(.PINS(8), .WAKE_CYCLES(20)) i_rcc_device (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .link(link), .reference_clock_input(refclk), .func_out(func_out),
    .func_oe(func_oe), .func_in(func_in), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .xor_out(xor_out), .clk48_enable(clk48_enable),
    .gen_powered(gen_powered), .gen_ready(gen_ready), .reserved_mode(reserved_mode));
  rcc_sva u_sva (.aclk(aclk), .aresetn(aresetn), .lreset_n(link.lreset_n),
    .bus_run(link.bus_run), .io_valid(link.io_valid), .io_addr(link.io_addr),
    .io_sync(link.io_sync), .strap_level(link.strap_level),
    .strap_pu_en(link.strap_pu_en), .strap_drive_oe(link.strap_drive_oe));

  // ********
  // reporting
  // ********
  task print_verdict;
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // a wait that ran out its bound ends the run
  task stall(input int cnt, input int lim);
    if (cnt >= lim) begin
      num_errors++;
      print_verdict();
    end
  endtask

  // ********
  // axi4-lite master
  // ********
  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid && k < 200);
    bready <= 1'h0;
    check(32'(bresp), 32'(RESP_OKAY));
    stall(k, 200);
  endtask

  task axi_rd(input logic [3:0] a, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'h0;
    end while (!rvalid && k < 200);
    rd_data = rdata;
    rready <= 1'h0;
    check(32'(rresp), 32'(er));
    stall(k, 200);
  endtask

  // one byte cycle on the link, status left in st
  task io(input logic [15:0] a, input logic wr, input logic [7:0] d);
    int k;
    k = 0;
    axi_wr(REG_CMD, {7'h0, wr, d, a});
    do begin
      axi_rd(REG_STATUS, RESP_OKAY);
      k++;
    end while (rd_data[ST_BUSY] !== 1'h0 && k < 200);
    st = rd_data;
    stall(k, 200);
  endtask

  // register model: unwritten places read 00h, dma places 04h
  function automatic logic [7:0] cfg_rd(input int idx);
    if (cfg.exists(idx)) return 8'(cfg[idx]);
    return (idx == 8'h74 || idx == 8'h75) ? DMA_NONE : 8'h00;
  endfunction

  task cfg_io(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    io(base_a, 1'h1, idx);
    io(base_a + 16'h1, wr, d);
    check(32'(st[ST_NOSYNC]), 32'h0);
    if (wr) cfg[int'(idx)] = d;
    else check(32'(st[15:8]), 32'(cfg_rd(int'(idx))));
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    void'($urandom(32'hC487A249));
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    // every test mode strap pair, base strap random each time
    for (int m = 0; m < 4; m++) begin
      if (m > 0) begin
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
      end
      strap = {~m[1], ~m[0], 1'($urandom)};
      pad_in <= 8'($urandom);
      func_oe <= 8'($urandom);
      func_out <= 8'($urandom);
      cfg.delete();
      axi_wr(REG_STRAP, {29'h0, strap});
      base_a = strap[0] ? BASE_HIGH : BASE_LOW;
      check(32'(link.strap_pu_en), 32'h1);
      check(32'(pad_oe[2:0]), 32'h0);
      io(base_a, 1'h1, IDX_LDN);
      check(32'(st[ST_NOSYNC]), 32'h1);
      axi_wr(REG_CTRL, 32'h1);
      repeat (4) @(posedge aclk);
      check(32'(link.strap_drive_oe), 32'h1);
      check(32'(pad_oe), (m == 0) ? 32'(func_oe) : 32'h0);
      check(32'(reserved_mode), 32'(m == 3));
      check(32'(xor_out), (m == 2) ? 32'(^pad_in) : 32'h0);
      check(32'(pad_out), 32'(func_out));
      check(32'(func_in), 32'(pad_in));
      io(strap[0] ? BASE_LOW : BASE_HIGH, 1'h1, IDX_LDN);
      check(32'(st[ST_NOSYNC]), 32'h1);
      cfg_io(IDX_LDN, 1'h1, 8'($urandom));
      cfg_io(IDX_LDN, 1'h0, 8'h0);
    end
    // host reset pulse brings config back to defaults; clock stop allowed from here
    axi_wr(REG_CTRL, 32'h0);
    axi_wr(REG_CTRL, 32'h3);
    check(32'(link.bus_run), 32'h0);
    cfg.delete();
    cfg_io(IDX_LDN, 1'h0, 8'h0);
    cfg_io(IDX_DMA0, 1'h0, 8'h0);
    axi_rd(4'h2, RESP_SLVERR);
    check(rd_data, 32'h0);
    // generator from the 14.31818 MHz reference
    cfg_io(IDX_CLKGEN, 1'h1, 8'hA0);
    cfg_io(IDX_CLKGEN, 1'h0, 8'h0);
    check(32'(clk48_enable), 32'h0);
    n = 0;
    do begin
      io(base_a + 16'h1, 1'h0, 8'h0);
      n++;
    end while (st[8 + CG_READY] !== 1'h1 && n < 60);
    stall(n, 60);
    check(32'(st[15:8]), 32'hB0);
    check(32'({clk48_enable, gen_ready}), 32'h3);
    cfg_io(IDX_CLKGEN, 1'h1, 8'h20);
    check(32'({clk48_enable, gen_ready, gen_powered}), 32'h0);
    // direct source with the lock set: later control writes are ignored
    cfg_io(IDX_CLKGEN, 1'h1, 8'h81);
    check(32'(clk48_enable), 32'h1);
    io(base_a + 16'h1, 1'h1, 8'h00);
    check(32'(clk48_enable), 32'h1);
    axi_wr(REG_CTRL, 32'h0);
    repeat (2) @(posedge aclk);
    check(32'(clk48_enable), 32'h0);
    // host reset must have cleared the lock
    axi_wr(REG_CTRL, 32'h1);
    cfg.delete();
    cfg_io(IDX_CLKGEN, 1'h1, 8'h80);
    check(32'(clk48_enable), 32'h1);
    print_verdict();
  end
endmodule
